// >>> verilog/psrc_defs.vh
// Purpose: Constants for the power-state and reset controller.
// Assumes: Avalon-MM byte addresses, 32-bit data, 250 MHz clock.
// Notes: Offsets and timing counts are used by the design; the bench uses its own literals.
`ifndef PSRC_DEFS_VH
`define PSRC_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PSRC_OFS_PWR_CTRL 8'h00
`define PSRC_OFS_INTERRUPT_STATUS_REGISTER 8'h04
`define PSRC_OFS_WAKE_WR 8'h08
`define PSRC_OFS_RST_CTRL 8'h0C
`define PSRC_OFS_EEP_CMD 8'h10
`define PSRC_OFS_PHY_CTRL 8'h14
`define PSRC_OFS_MAC_HI 8'h18
`define PSRC_OFS_MAC_LO 8'h1C

// ****************************************
// Field positions
// ****************************************
`define PSRC_B_READY 0
`define PSRC_B_WAKE_PIN_EN 1
`define PSRC_B_PULSE_SEL 3
`define PSRC_B_WAKE_STS_LO 4
`define PSRC_B_FRAME_EN 9
`define PSRC_B_ENERGY_EN 14
`define PSRC_B_STATE_LO 12
`define PSRC_B_WAKE_INT 17
`define PSRC_B_SOFT_RST 0
`define PSRC_B_PHY_RST 10
`define PSRC_B_EEP_BUSY 31
`define PSRC_B_PHY_PDOWN 11
`define PSRC_B_PHY_EDPD 13
`define PSRC_B_PHY_ENERGY_INT 1
`define PSRC_B_PHY_LINK 2

// ****************************************
// Encodings and reset values
// ****************************************
`define PSRC_ST_NORMAL 2'h0
`define PSRC_ST_WOL 2'h1
`define PSRC_ST_ED 2'h2
`define PSRC_WS_FRAME 2'h2
`define PSRC_WS_ENERGY 2'h1
`define PSRC_WS_NONE 2'h0

// ****************************************
// Timing, in microseconds and cycles at 250 MHz
// ****************************************
`define PSRC_CLK_MHZ 250
`define PSRC_POR_US 22000
`define PSRC_PULSE_US 50000
`define PSRC_WAKE_US 2000
`define PSRC_SOFT_RESET_US 2
`define PSRC_PHYRST_US 100
`define PSRC_EEP_US 10
`define PSRC_POR_CYC (`PSRC_POR_US * `PSRC_CLK_MHZ)
`define PSRC_PULSE_CYC (`PSRC_PULSE_US * `PSRC_CLK_MHZ)
`define PSRC_WAKE_CYC (`PSRC_WAKE_US * `PSRC_CLK_MHZ)
`define PSRC_SOFT_RESET_CYC (`PSRC_SOFT_RESET_US * `PSRC_CLK_MHZ)
`define PSRC_PHYRST_CYC (`PSRC_PHYRST_US * `PSRC_CLK_MHZ)
`define PSRC_EEP_CYC (`PSRC_EEP_US * `PSRC_CLK_MHZ)

`endif

// >>> verilog/psrc_top.v
// Purpose: Power-state sequencing, wake indication and reset control.
// Assumes: Registers on Avalon-MM; pins pass a three-stage synchroniser.
// Notes: Long counts are parameters so simulation can shorten them.
//
// What this block does
// - Writing 01 to state select enters WOL sleep, clears ready, gates host clocks.
// - WOL sleep arms frame detection; a detection sets wake status to 10b.
// - Frame detect with frame enable and pin enable drives the wake pin.
// - Any wake event sets the wake interrupt flag regardless of pin enable.
// - Any wake-register write in sleep returns to normal, state select to 00.
// - Energy sleep gates host and internal clocks; PHY energy mode is set by its own PHY control bit.
// - Energy sleep carrier sets status 01b; enables drive pin; present carrier counts.
// - Wake flag holds while event active; then write-one clears it.
// - Pulse select 1 gives a 50 ms pin pulse; 0 holds until cleared.
// - Pin drops when status, matching detect enable or pin enable clears.
// - PHY general powerdown bit holds PHY down; clearing it resets the PHY.
// - Energy powerdown follows line energy; energy arrival sets PHY flag 7.1.
// - Hardware reset clears everything; soft reset spares exempt regs; PHY resets PHY only.
// - After chip or soft reset an EEPROM check holds busy bit 31.
// - Power-on holds internal reset about 22 ms with ready at 0.
// - Hardware reset pin low resets; ready reads 0 until done.
// - After wake write, ready sets within 2 ms.
// - In sleep only power control reads and the wake write are served.
`default_nettype none
`include "psrc_defs.vh"

module psrc_top #(
  parameter POR_CYC = `PSRC_POR_CYC,
  parameter PULSE_CYC = `PSRC_PULSE_CYC,
  parameter WAKE_CYC = `PSRC_WAKE_CYC,
  parameter PHYRST_CYC = `PSRC_PHYRST_CYC,
  parameter SOFT_RESET_CYC = `PSRC_SOFT_RESET_CYC,
  parameter EEP_CYC = `PSRC_EEP_CYC
) (
  // Clock, reset, enable
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_clk_en,
  // Avalon-MM slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Pins and detector inputs
  input wire i_hardware_reset_n,
  input wire i_line_energy_present,
  input wire i_frame_detected,
  // Outputs
  output reg o_wake_event_pin,
  output reg o_wake_irq,
  output reg o_host_clk_gate_n,
  output reg o_int_clk_gate_n,
  output reg o_phy_powered,
  output reg o_phy_reset,
  output reg o_mac_reset,
  output reg o_straps_latch
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [2:0] nrst_sync_q;
  reg [2:0] energy_sync_q;
  reg nrst_q;
  reg energy_q;

  always @(posedge i_clk_sys)
  begin
    if (i_clk_en)
    begin
      nrst_sync_q <= {nrst_sync_q[1:0], i_hardware_reset_n};
      energy_sync_q <= {energy_sync_q[1:0], i_line_energy_present};
      if (nrst_sync_q[2] == nrst_sync_q[1])
        nrst_q <= nrst_sync_q[2];
      if (energy_sync_q[2] == energy_sync_q[1])
        energy_q <= energy_sync_q[2];
    end
  end

  // ****************************************
  // State and registers
  // ****************************************
  reg [1:0] state_q;
  reg [1:0] wake_sts_q;
  reg frame_en_q, energy_en_q, pin_en_q, pulse_sel_q, wake_int_q;
  reg ready_q, read_seen_q;
  reg [24:0] por_cnt_q;
  reg [19:0] wake_cnt_q;
  reg [24:0] pulse_cnt_q;
  reg [15:0] phy_cnt_q;
  reg [9:0] soft_reset_cnt_q;
  reg [11:0] eep_cnt_q;
  reg phy_pdown_q, phy_edpd_q, phy_eint_q, phy_link_q;
  reg [31:0] mac_hi_q, mac_lo_q;
  reg pin_armed_q;
  reg energy_d1_q;
  reg [31:0] rdata;

  wire hw_rst = i_rst | ~nrst_q;
  wire por_busy = (por_cnt_q != 25'h0000000);
  wire acc = i_avs_read | i_avs_write;
  wire take = acc & o_avs_waitrequest & i_clk_en;
  // A write commits at the edge where the master sees waitrequest low.
  wire fin = acc & ~o_avs_waitrequest & i_clk_en;
  wire sleeping = (state_q != `PSRC_ST_NORMAL);
  wire eep_busy = (eep_cnt_q != 12'h000);
  wire soft_reset_busy = (soft_reset_cnt_q != 10'h000);
  wire is_pwr = (i_avs_address == `PSRC_OFS_PWR_CTRL);
  wire is_wake = (i_avs_address == `PSRC_OFS_WAKE_WR);
  // Sleep blocks everything except control reads and the wake write.
  wire allow = sleeping ? ((i_avs_read & is_pwr) | (i_avs_write & is_wake)) : 1'b1;
  // Writes take effect only after the first read since reset or wake.
  wire wr = fin & i_avs_write & allow & (read_seen_q | sleeping) & ready_q;
  wire wr_wake = fin & i_avs_write & sleeping & is_wake;
  wire frame_hit = (state_q == `PSRC_ST_WOL) & i_frame_detected;
  wire energy_hit = (state_q == `PSRC_ST_ED) & energy_q;
  // Internal wake event stays up while status and its enable stand.
  wire event_act = ((wake_sts_q == `PSRC_WS_FRAME) & frame_en_q) |
                   ((wake_sts_q == `PSRC_WS_ENERGY) & energy_en_q);
  wire pin_cond = event_act & pin_en_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      for (k = 0; k < 32; k = k + 1)
        merge[k] = be[k / 8] ? nw[k] : old[k];
    end
  endfunction

  wire [31:0] wd = merge(32'h00000000, i_avs_writedata, i_avs_byteenable);

  always @(posedge i_clk_sys)
  begin
    if (hw_rst)
    begin
      // Full chip reset clears every domain and restarts the power-on timer.
      por_cnt_q <= POR_CYC[24:0];
      state_q <= `PSRC_ST_NORMAL;
      wake_sts_q <= `PSRC_WS_NONE;
      frame_en_q <= 1'b0;
      energy_en_q <= 1'b0;
      pin_en_q <= 1'b0;
      pulse_sel_q <= 1'b0;
      wake_int_q <= 1'b0;
      ready_q <= 1'b0;
      read_seen_q <= 1'b0;
      wake_cnt_q <= 20'h00000;
      pulse_cnt_q <= 25'h0000000;
      phy_cnt_q <= PHYRST_CYC[15:0];
      soft_reset_cnt_q <= 10'h000;
      eep_cnt_q <= EEP_CYC[11:0];
      phy_pdown_q <= 1'b0;
      phy_edpd_q <= 1'b0;
      phy_eint_q <= 1'b0;
      phy_link_q <= 1'b0;
      mac_hi_q <= 32'h00000000;
      mac_lo_q <= 32'h00000000;
      pin_armed_q <= 1'b0;
      energy_d1_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      o_wake_event_pin <= 1'b0;
      o_wake_irq <= 1'b0;
      o_host_clk_gate_n <= 1'b0;
      o_int_clk_gate_n <= 1'b1;
      o_phy_powered <= 1'b0;
      o_phy_reset <= 1'b1;
      o_mac_reset <= 1'b1;
      o_straps_latch <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_straps_latch <= 1'b0;
      if (por_busy)
        por_cnt_q <= por_cnt_q - 25'h0000001;
      // Ready rises once awake and no power-on, soft reset or wake sequence is pending.
      if (wake_cnt_q != 20'h00000)
        wake_cnt_q <= wake_cnt_q - 20'h00001;
      ready_q <= ~por_busy & ~soft_reset_busy & ~sleeping & (wake_cnt_q <= 20'h00001);
      if (soft_reset_busy)
        soft_reset_cnt_q <= soft_reset_cnt_q - 10'h001;
      if (eep_busy)
        eep_cnt_q <= eep_cnt_q - 12'h001;
      if (phy_cnt_q != 16'h0000)
        phy_cnt_q <= phy_cnt_q - 16'h0001;
      o_mac_reset <= por_busy | soft_reset_busy;
      o_phy_reset <= por_busy | (phy_cnt_q != 16'h0000);
      // Link comes up only after PHY reset ends and the PHY is up.
      phy_link_q <= (phy_cnt_q == 16'h0000) & o_phy_powered & energy_q;
      // General powerdown and energy powerdown gate PHY power.
      o_phy_powered <= ~phy_pdown_q & (~phy_edpd_q | energy_q);
      energy_d1_q <= energy_q;
      // Clock gating follows the sleep state.
      o_host_clk_gate_n <= ~sleeping & ~por_busy;
      o_int_clk_gate_n <= (state_q != `PSRC_ST_ED);

      // Detection and status; hardware set wins over a software clear.
      if (frame_hit)
        wake_sts_q <= `PSRC_WS_FRAME;
      else if (energy_hit)
        wake_sts_q <= `PSRC_WS_ENERGY;
      else if (wr && i_avs_address == `PSRC_OFS_PWR_CTRL && i_avs_byteenable[0])
        wake_sts_q <= wake_sts_q & ~wd[`PSRC_B_WAKE_STS_LO +: 2];

      // Flag sets on any event; write-one clears only once the event is gone.
      if (event_act | frame_hit | energy_hit)
        wake_int_q <= 1'b1;
      else if (wr && i_avs_address == `PSRC_OFS_INTERRUPT_STATUS_REGISTER && wd[`PSRC_B_WAKE_INT])
        wake_int_q <= 1'b0;
      o_wake_irq <= wake_int_q;

      // Energy arrival in energy powerdown raises PHY flag.
      if (phy_edpd_q & energy_q & ~energy_d1_q)
        phy_eint_q <= 1'b1;
      else if (wr && i_avs_address == `PSRC_OFS_PHY_CTRL && wd[`PSRC_B_PHY_ENERGY_INT])
        phy_eint_q <= 1'b0;

      // Wake pin: pulse or level, deasserted when the cause goes.
      if (!pin_cond)
      begin
        pin_armed_q <= 1'b0;
        pulse_cnt_q <= 25'h0000000;
        o_wake_event_pin <= 1'b0;
      end
      else if (!pin_armed_q)
      begin
        pin_armed_q <= 1'b1;
        pulse_cnt_q <= PULSE_CYC[24:0];
        o_wake_event_pin <= 1'b1;
      end
      else if (pulse_sel_q)
      begin
        if (pulse_cnt_q != 25'h0000000)
          pulse_cnt_q <= pulse_cnt_q - 25'h0000001;
        o_wake_event_pin <= (pulse_cnt_q > 25'h0000001);
      end
      else
        o_wake_event_pin <= 1'b1;

      // Sleep entry and wake write.
      if (wr_wake)
      begin
        state_q <= `PSRC_ST_NORMAL;
        wake_cnt_q <= WAKE_CYC[19:0];
        read_seen_q <= 1'b0;
        ready_q <= 1'b0;
      end
      else if (wr && is_pwr && i_avs_byteenable[1])
      begin
        if (wd[`PSRC_B_STATE_LO +: 2] == `PSRC_ST_WOL || wd[`PSRC_B_STATE_LO +: 2] == `PSRC_ST_ED)
        begin
          state_q <= wd[`PSRC_B_STATE_LO +: 2];
          ready_q <= 1'b0;
        end
      end
      if (wr && is_pwr)
      begin
        if (i_avs_byteenable[0])
        begin
          pin_en_q <= wd[`PSRC_B_WAKE_PIN_EN];
          pulse_sel_q <= wd[`PSRC_B_PULSE_SEL];
        end
        if (i_avs_byteenable[1])
        begin
          frame_en_q <= wd[`PSRC_B_FRAME_EN];
          energy_en_q <= wd[`PSRC_B_ENERGY_EN];
          if (wd[`PSRC_B_PHY_RST])
            phy_cnt_q <= PHYRST_CYC[15:0];
        end
      end
      // Soft reset spares exempt registers and the PHY.
      if (wr && i_avs_address == `PSRC_OFS_RST_CTRL && wd[`PSRC_B_SOFT_RST])
      begin
        soft_reset_cnt_q <= SOFT_RESET_CYC[9:0];
        eep_cnt_q <= EEP_CYC[11:0];
        read_seen_q <= 1'b0;
        ready_q <= 1'b0;
      end
      if (wr && i_avs_address == `PSRC_OFS_PHY_CTRL)
      begin
        if (i_avs_byteenable[1])
        begin
          phy_pdown_q <= wd[`PSRC_B_PHY_PDOWN];
          phy_edpd_q <= wd[`PSRC_B_PHY_EDPD];
          // Leaving general powerdown resets the PHY.
          if (phy_pdown_q & ~wd[`PSRC_B_PHY_PDOWN])
            phy_cnt_q <= PHYRST_CYC[15:0];
        end
      end
      // MAC address writes are dropped while the EEPROM check runs.
      if (wr && !eep_busy && i_avs_address == `PSRC_OFS_MAC_HI)
        mac_hi_q <= merge(mac_hi_q, i_avs_writedata, i_avs_byteenable);
      if (wr && !eep_busy && i_avs_address == `PSRC_OFS_MAC_LO)
        mac_lo_q <= merge(mac_lo_q, i_avs_writedata, i_avs_byteenable);

      // Bus answer: one wait cycle, then waitrequest low for one edge.
      if (take)
      begin
        o_avs_waitrequest <= 1'b0;
        if (i_avs_read)
        begin
          read_seen_q <= 1'b1;
          o_avs_readdata <= allow ? rdata : 32'h00000000;
        end
      end
      else
        o_avs_waitrequest <= 1'b1;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @*
  begin
    rdata = 32'h00000000;
    case (i_avs_address)
      `PSRC_OFS_PWR_CTRL:
      begin
        rdata[`PSRC_B_READY] = ready_q;
        rdata[`PSRC_B_WAKE_PIN_EN] = pin_en_q;
        rdata[`PSRC_B_PULSE_SEL] = pulse_sel_q;
        rdata[`PSRC_B_WAKE_STS_LO +: 2] = wake_sts_q;
        rdata[`PSRC_B_FRAME_EN] = frame_en_q;
        rdata[`PSRC_B_PHY_RST] = (phy_cnt_q != 16'h0000);
        rdata[`PSRC_B_STATE_LO +: 2] = state_q;
        rdata[`PSRC_B_ENERGY_EN] = energy_en_q;
      end
      `PSRC_OFS_INTERRUPT_STATUS_REGISTER: rdata[`PSRC_B_WAKE_INT] = wake_int_q;
      `PSRC_OFS_RST_CTRL: rdata[`PSRC_B_SOFT_RST] = soft_reset_busy;
      `PSRC_OFS_EEP_CMD: rdata[`PSRC_B_EEP_BUSY] = eep_busy;
      `PSRC_OFS_PHY_CTRL:
      begin
        rdata[`PSRC_B_PHY_ENERGY_INT] = phy_eint_q;
        rdata[`PSRC_B_PHY_LINK] = phy_link_q;
        rdata[`PSRC_B_PHY_PDOWN] = phy_pdown_q;
        rdata[`PSRC_B_PHY_EDPD] = phy_edpd_q;
      end
      `PSRC_OFS_MAC_HI: rdata = mac_hi_q;
      `PSRC_OFS_MAC_LO: rdata = mac_lo_q;
      default: rdata = 32'h00000000;
    endcase
  end

endmodule
`default_nettype wire

// >>> verification/psrc_top_chk.sv
// Purpose: Port assertions for the power-state and reset controller.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to psrc_top at the foot of this file.
`default_nettype none
module psrc_top_chk (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Status outputs
  input wire logic o_wake_event_pin,
  input wire logic o_wake_irq,
  input wire logic o_host_clk_gate_n,
  input wire logic o_int_clk_gate_n,
  input wire logic o_phy_reset,
  input wire logic o_mac_reset,
  input wire logic o_straps_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en;
  endsequence
  sequence s_ans;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_idle;
    !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write);
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rdstab;
    o_avs_waitrequest && $past(o_avs_waitrequest) && !o_mac_reset && !$past(o_mac_reset)
      |-> $stable(o_avs_readdata);
  endproperty
  a_rdstab: assert property (p_rdstab) else $error("read data moved");
  property p_irq_pin;
    $rose(o_wake_event_pin) |-> ##[0:4] o_wake_irq;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("pin without flag");
  property p_ed;
    !o_int_clk_gate_n |-> !o_host_clk_gate_n;
  endproperty
  a_ed: assert property (p_ed) else $error("host clock runs in energy sleep");
  property p_straps;
    $rose(o_straps_latch) |-> o_phy_reset && o_mac_reset;
  endproperty
  a_straps: assert property (p_straps) else $error("straps without full reset");
  property p_irq_fall;
    $fell(o_wake_irq) |-> $past(i_avs_write) || $past(i_avs_write, 2) || o_mac_reset;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("flag fell unasked");
  property p_rst;
    disable iff (1'b0)
    i_rst |=> o_avs_waitrequest && o_mac_reset && o_phy_reset && o_straps_latch
      && !o_wake_event_pin && !o_wake_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind psrc_top psrc_top_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_en(i_clk_en),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_wake_event_pin(o_wake_event_pin),
  .o_wake_irq(o_wake_irq), .o_host_clk_gate_n(o_host_clk_gate_n),
  .o_int_clk_gate_n(o_int_clk_gate_n), .o_phy_reset(o_phy_reset),
  .o_mac_reset(o_mac_reset), .o_straps_latch(o_straps_latch));
`default_nettype wire

// >>> verification/psrc_line_model.sv
// Purpose: Far-side model of the frame filter and line energy detector.
// Assumes: Same clock as the block.
// Notes: Frame detection answers slowly, energy promptly.
`default_nettype none
module psrc_line_model #(
  parameter int FRAME_DLY = 5
) (
  input wire logic i_clk,
  input wire logic i_frame_req,
  input wire logic i_energy_req,
  output var logic o_frame_detected = 1'b0,
  output var logic o_line_energy_present = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  always @(posedge i_clk)
  begin
    cnt_q <= i_frame_req ? cnt_q + 1 : 0;
    o_frame_detected <= i_frame_req && cnt_q >= FRAME_DLY;
    o_line_energy_present <= i_energy_req;
  end
endmodule
`default_nettype wire

// >>> verification/psrc_top_tb.sv
// Purpose: Self-checking bench for the power-state and reset controller.
// Assumes: Shortened counts; Avalon-MM master tasks.
// Notes: Sleep entry, wake, pin modes and pin reset.
`default_nettype none
module psrc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hw_rst_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic frame_req = 1'b0;
  logic energy_req = 1'b0;
  logic frame_det, energy_on, waitreq, pin, irq, hgate, igate;
  logic ce = 1'b1;
  logic [3:0] be = 4'hF;
  logic phy_pw, phy_rst_o, mac_rst_o, straps;
  logic [31:0] rdata, q;
  int err_total = 0;
  int n_tests = 0;
  initial
  begin
    forever #2 clk = ~clk;
  end
  psrc_top #(.POR_CYC(50), .PULSE_CYC(20), .WAKE_CYC(10), .PHYRST_CYC(10), .SOFT_RESET_CYC(5),
    .EEP_CYC(8)) u_dut (.i_clk_sys(clk), .i_rst(rst), .i_clk_en(ce), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_hardware_reset_n(hw_rst_n),
    .i_line_energy_present(energy_on), .i_frame_detected(frame_det), .o_wake_event_pin(pin),
    .o_wake_irq(irq), .o_host_clk_gate_n(hgate), .o_int_clk_gate_n(igate),
    .o_phy_powered(phy_pw), .o_phy_reset(phy_rst_o), .o_mac_reset(mac_rst_o),
    .o_straps_latch(straps));
  psrc_line_model #(.FRAME_DLY(5)) u_line (.i_clk(clk), .i_frame_req(frame_req),
    .i_energy_req(energy_req), .o_frame_detected(frame_det),
    .o_line_energy_present(energy_on));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      $display("[FAIL] %0t bus timeout", $time);
      end_of_test();
    end
  endtask
  task automatic poll(input int lim, input string m);
    int k;
    k = 0;
    do
    begin
      bus(1'b0, 8'h00, 32'h0);
      k++;
    end
    while (q[0] !== 1'b1 && k < lim);
    chk(32'(q[0]), 32'h1, m);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0);
    chk(32'(q[0]), 32'h0, "rdy por");
    poll(40, "rdy after por");
    chk(32'(mac_rst_o), 32'h0, "mac reset end");
    chk(32'(straps), 32'h0, "straps end");
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(waitreq), 32'h1, "frozen bus");
    ce <= 1'b1;
    $display("test power-on done");
    bus(1'b1, 8'h00, 32'h0000_0202);
    bus(1'b1, 8'h00, 32'h0000_1202);
    bus(1'b0, 8'h00, 32'h0);
    chk(32'(q[0]), 32'h0, "rdy wol");
    chk(32'(hgate), 32'h0, "host clk wol");
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0, "sleep read");
    frame_req <= 1'b1;
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0);
    chk(32'(q[5:4]), 32'h2, "status frame");
    chk(32'(pin), 32'h1, "pin frame");
    chk(32'(irq), 32'h1, "flag frame");
    frame_req <= 1'b0;
    bus(1'b1, 8'h08, 32'h0000_1234);
    poll(6, "rdy wake");
    bus(1'b0, 8'h00, 32'h0);
    chk(32'(q[13:12]), 32'h0, "state wake");
    chk(32'(q[5:4]), 32'h2, "status kept");
    chk(32'(q[9]), 32'h1, "enable kept");
    repeat (30) @(posedge clk);
    chk(32'(pin), 32'h1, "static pin");
    bus(1'b1, 8'h00, 32'h0000_0200);
    repeat (4) @(posedge clk);
    chk(32'(pin), 32'h0, "pin off");
    bus(1'b1, 8'h04, 32'h0002_0000);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h1, "flag held");
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0002_0000);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0, "flag clear");
    $display("test wol sleep done");
    hw_rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    hw_rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0);
    chk(32'(q[0]), 32'h0, "rdy pin rst");
    poll(40, "rdy after pin rst");
    chk(32'(q[5:4]), 32'h0, "status rst");
    bus(1'b0, 8'h10, 32'h0);
    chk(32'(q[31]), 32'h0, "eeprom idle");
    be <= 4'h1;
    bus(1'b1, 8'h18, 32'hAABBCCDD);
    be <= 4'hF;
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h000000DD, "mac lane");
    $display("test pin reset done");
    energy_req <= 1'b1;
    bus(1'b1, 8'h14, 32'h0000_2000);
    bus(1'b1, 8'h00, 32'h0000_600A);
    repeat (8) @(posedge clk);
    chk(32'(pin), 32'h1, "pin energy");
    chk(32'(igate), 32'h0, "int clk ed");
    bus(1'b0, 8'h00, 32'h0);
    chk(32'(q[5:4]), 32'h1, "status energy");
    repeat (25) @(posedge clk);
    chk(32'(pin), 32'h0, "pulse end");
    bus(1'b1, 8'h08, 32'h0);
    poll(6, "rdy ed wake");
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk(32'(q[2]), 32'h1, "link up");
    chk(32'(phy_pw), 32'h1, "phy powered");
    chk(32'(phy_rst_o), 32'h0, "phy out of reset");
    energy_req <= 1'b0;
    $display("test energy sleep done");
    end_of_test();
  end
endmodule
`default_nettype wire
